//--- pmc_pkg.sv
// package of the power mode controller: mode codes, widths, timing counts
// assumes a single system clock domain at 250 mhz
package pmc_pkg;
	localparam int NUM_PERIPH = 8;
	localparam logic [1:0] MODE_RUN = 2'h0;
	localparam logic [1:0] MODE_IDLE = 2'h1;
	localparam logic [1:0] MODE_SLEEP = 2'h2;
	localparam int CLK_PERIOD_NS = 4;
	// automatic unit gating: idle time before a unit's clock is stopped
	localparam int AUTO_OFF_NS = 400;
	localparam int AUTO_OFF_CYC = (AUTO_OFF_NS / CLK_PERIOD_NS < 1) ? 1
		: AUTO_OFF_NS / CLK_PERIOD_NS;
	localparam int AUTO_CNT_W = 8;
	localparam logic [AUTO_CNT_W-1:0] AUTO_OFF_LIM = AUTO_CNT_W'(AUTO_OFF_CYC);
	typedef enum logic [2:0] {
		PMC_RUN,
		PMC_IDLE,
		PMC_SUSP_REQ,
		PMC_SLEEP
	} pmc_state_t;
endpackage

//--- pmc_power_mode_controller.sv
// power mode controller: run, idle and sleep, with wake-up and per-peripheral gating
// assumes the processor requests modes by a one-cycle pulse and peripherals ack suspend
`timescale 1ns/100ps
module pmc_power_mode_controller (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic mode_req,
	input wire logic [1:0] mode_sel,
	input wire logic [pmc_pkg::NUM_PERIPH-1:0] run_clk_en,
	input wire logic [pmc_pkg::NUM_PERIPH-1:0] idle_clk_en,
	input wire logic [pmc_pkg::NUM_PERIPH-1:0] sleep_clk_en,
	input wire logic [pmc_pkg::NUM_PERIPH-1:0] periph_busy,
	input wire logic [pmc_pkg::NUM_PERIPH-1:0] periph_irq,
	input wire logic [pmc_pkg::NUM_PERIPH-1:0] irq_en,
	input wire logic [pmc_pkg::NUM_PERIPH-1:0] susp_ack,
	input wire logic wdt_event,
	input wire logic nmi_pin,
	output logic cpu_clk_en,
	output logic mem_access_en,
	output logic [pmc_pkg::NUM_PERIPH-1:0] periph_clk_en,
	output logic [pmc_pkg::NUM_PERIPH-1:0] periph_suspend,
	output logic [1:0] mode_status
);
	localparam int N = pmc_pkg::NUM_PERIPH;

	////////////////////////////////////////////////////////////////////////////
	pmc_pkg::pmc_state_t state;
	pmc_pkg::pmc_state_t next_state;
	logic nmi_q;
	logic next_nmi_q;
	logic next_cpu_clk_en;
	logic next_mem_access_en;
	logic [1:0] next_mode_status;
	logic [N-1:0] next_suspend;
	logic [N-1:0] next_gate;
	logic [N-1:0] awake;
	logic nmi_fall;
	logic idle_wake;
	logic sleep_wake;

	assign nmi_fall = nmi_q & ~nmi_pin;
	assign idle_wake = wdt_event | nmi_fall | |(periph_irq & irq_en);
	assign sleep_wake = wdt_event | nmi_fall | |(periph_irq & irq_en & sleep_clk_en);

	always_comb begin
		next_state = state;
		next_nmi_q = nmi_pin;
		unique case (state)
			pmc_pkg::PMC_RUN: begin
				if (mode_req && mode_sel == pmc_pkg::MODE_IDLE) begin
					next_state = pmc_pkg::PMC_IDLE;
				end else if (mode_req && mode_sel == pmc_pkg::MODE_SLEEP) begin
					next_state = pmc_pkg::PMC_SUSP_REQ;
				end
			end
			pmc_pkg::PMC_IDLE: begin
				if (idle_wake) begin
					next_state = pmc_pkg::PMC_RUN;
				end
			end
			pmc_pkg::PMC_SUSP_REQ: begin
				if (sleep_wake) begin
					next_state = pmc_pkg::PMC_RUN;
				end else if ((susp_ack | sleep_clk_en) == {N{1'b1}}) begin
					next_state = pmc_pkg::PMC_SLEEP;
				end
			end
			pmc_pkg::PMC_SLEEP: begin
				if (sleep_wake) begin
					next_state = pmc_pkg::PMC_RUN;
				end
			end
			default: next_state = pmc_pkg::PMC_RUN;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state <= pmc_pkg::PMC_RUN;
			nmi_q <= 1'b1;
		end else begin
			state <= next_state;
			nmi_q <= next_nmi_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// automatic gating of units that stay unused for a while
	logic [N-1:0][pmc_pkg::AUTO_CNT_W-1:0] idle_cnt;
	logic [N-1:0][pmc_pkg::AUTO_CNT_W-1:0] next_idle_cnt;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_auto
			always_comb begin
				if (periph_busy[g] || periph_irq[g]) begin
					next_idle_cnt[g] = '0;
				end else if (idle_cnt[g] != pmc_pkg::AUTO_OFF_LIM) begin
					next_idle_cnt[g] = idle_cnt[g] + pmc_pkg::AUTO_CNT_W'(1);
				end else begin
					next_idle_cnt[g] = idle_cnt[g];
				end
			end
			assign awake[g] = periph_busy[g] || idle_cnt[g] != pmc_pkg::AUTO_OFF_LIM;
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			idle_cnt <= '0;
		end else begin
			idle_cnt <= next_idle_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, registered from the next state
	always_comb begin
		next_cpu_clk_en = 1'b1;
		next_mem_access_en = 1'b1;
		next_suspend = '0;
		next_gate = run_clk_en & awake;
		next_mode_status = pmc_pkg::MODE_RUN;
		unique case (next_state)
			pmc_pkg::PMC_RUN: ;
			pmc_pkg::PMC_IDLE: begin
				next_cpu_clk_en = 1'b0;
				next_mem_access_en = 1'b1;
				next_gate = (idle_clk_en | run_clk_en) & awake;
				next_mode_status = pmc_pkg::MODE_IDLE;
			end
			pmc_pkg::PMC_SUSP_REQ: begin
				// run clocks stay until each unit acks; clocks that were off stay off
				next_cpu_clk_en = 1'b0;
				next_suspend = ~sleep_clk_en;
				next_gate = run_clk_en & ~susp_ack & awake;
				next_mode_status = pmc_pkg::MODE_SLEEP;
			end
			pmc_pkg::PMC_SLEEP: begin
				next_cpu_clk_en = 1'b0;
				next_mem_access_en = 1'b0;
				next_suspend = ~sleep_clk_en;
				next_gate = sleep_clk_en & awake;
				next_mode_status = pmc_pkg::MODE_SLEEP;
			end
			default: ;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cpu_clk_en <= 1'b1;
			mem_access_en <= 1'b1;
			periph_clk_en <= '0;
			periph_suspend <= '0;
			mode_status <= pmc_pkg::MODE_RUN;
		end else begin
			cpu_clk_en <= next_cpu_clk_en;
			mem_access_en <= next_mem_access_en;
			periph_clk_en <= next_gate;
			periph_suspend <= next_suspend;
			mode_status <= next_mode_status;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	property p_idle_cpu_off;
		@(posedge core_clk) disable iff (!rst_b)
		(state == pmc_pkg::PMC_IDLE) |-> !cpu_clk_en;
	endproperty
	a_idle_cpu_off: assert property (p_idle_cpu_off) else $error("cpu clock on in idle");

	property p_idle_wake;
		@(posedge core_clk) disable iff (!rst_b)
		(state == pmc_pkg::PMC_IDLE && wdt_event) |=> (state == pmc_pkg::PMC_RUN) && cpu_clk_en;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");

	property p_sleep_wake;
		@(posedge core_clk) disable iff (!rst_b)
		(state == pmc_pkg::PMC_SLEEP && nmi_fall) |=> (state == pmc_pkg::PMC_RUN);
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep did not wake");

	property p_sleep_gate;
		@(posedge core_clk) disable iff (!rst_b)
		(state == pmc_pkg::PMC_SLEEP && $past(state) == pmc_pkg::PMC_SLEEP)
			|-> (periph_clk_en & ~$past(sleep_clk_en)) == '0;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("clock to halted unit");

	property p_sleep_susp;
		@(posedge core_clk) disable iff (!rst_b)
		(state == pmc_pkg::PMC_SLEEP) |-> periph_suspend == ~$past(sleep_clk_en);
	endproperty
	a_sleep_susp: assert property (p_sleep_susp) else $error("suspend wrong in sleep");

	property p_orderly;
		@(posedge core_clk) disable iff (!rst_b)
		(state == pmc_pkg::PMC_RUN) |=> (state != pmc_pkg::PMC_SLEEP);
	endproperty
	a_orderly: assert property (p_orderly) else $error("sleep without shutdown");

	property p_idle_mem;
		@(posedge core_clk) disable iff (!rst_b)
		(state == pmc_pkg::PMC_IDLE) |-> mem_access_en && mode_status == pmc_pkg::MODE_IDLE;
	endproperty
	a_idle_mem: assert property (p_idle_mem) else $error("memory blocked in idle");

	property p_ack_first;
		@(posedge core_clk) disable iff (!rst_b)
		(state == pmc_pkg::PMC_SUSP_REQ ##1 state == pmc_pkg::PMC_SLEEP)
			|-> ($past(susp_ack) | $past(sleep_clk_en)) == {N{1'b1}};
	endproperty
	a_ack_first: assert property (p_ack_first) else $error("gated before ack");
endmodule

//--- pmc_periph_model.sv
// partner: peripherals that acknowledge suspend some cycles late
// assumes the controller's clock and eight suspend lines
`timescale 1ns/100ps
module pmc_periph_model #(
	parameter int ACK_DLY = 3
) (
	input wire logic core_clk,
	input wire logic [7:0] periph_suspend,
	output logic [7:0] susp_ack
);
	logic [7:0] dly [ACK_DLY];
	always_ff @(posedge core_clk) begin
		dly[0] <= periph_suspend;
		// a dropped request clears the whole pipeline, so a new request waits the full delay
		for (int i = 1; i < ACK_DLY; i++) begin
			dly[i] <= dly[i-1] & periph_suspend;
		end
	end
	// ack drops at once with the request, rises only after the delay
	assign susp_ack = dly[ACK_DLY-1] & periph_suspend;
endmodule

//--- pmc_power_mode_controller_tb.sv
// testbench of the power mode controller: reset, idle, sleep, refusals, auto gating
// assumes pmc_pkg and the peripheral model are compiled first
`timescale 1ns/100ps
module pmc_power_mode_controller_tb;
	logic core_clk = 0, rst_b = 0, mode_req = 0, wdt_event = 0, nmi_pin = 1;
	logic cpu_clk_en, mem_access_en;
	logic [1:0] mode_sel = 2'h0, mode_status;
	logic [7:0] run_clk_en = 8'h3c, idle_clk_en = 8'h81, sleep_clk_en = 8'h05;
	logic [7:0] periph_busy = 8'hff, periph_irq = 8'h00, irq_en = 8'h0f;
	logic [7:0] susp_ack, periph_clk_en, periph_suspend;
	int n_mismatch = 0, compares = 0;
	always #2 core_clk = ~core_clk;
	pmc_power_mode_controller u_dut (.core_clk(core_clk), .rst_b(rst_b),
		.mode_req(mode_req), .mode_sel(mode_sel), .run_clk_en(run_clk_en),
		.idle_clk_en(idle_clk_en), .sleep_clk_en(sleep_clk_en), .periph_busy(periph_busy),
		.periph_irq(periph_irq), .irq_en(irq_en), .susp_ack(susp_ack),
		.wdt_event(wdt_event), .nmi_pin(nmi_pin), .cpu_clk_en(cpu_clk_en),
		.mem_access_en(mem_access_en), .periph_clk_en(periph_clk_en),
		.periph_suspend(periph_suspend), .mode_status(mode_status));
	pmc_periph_model #(.ACK_DLY(3)) u_periph (.core_clk(core_clk),
		.periph_suspend(periph_suspend), .susp_ack(susp_ack));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task req(input logic [1:0] s);
		mode_req = 1;
		mode_sel = s;
		cyc(1);
		mode_req = 0;
	endtask
	// one-cycle wake event, then bounded wait for run mode
	task wake(input int src);
		case (src)
			0: wdt_event = 1;
			1: nmi_pin = 0;
			default: periph_irq = 8'h01;
		endcase
		cyc(1);
		wdt_event = 0;
		periph_irq = 8'h00;
		for (int i = 0; i < 6 && mode_status !== 2'h0; i++) cyc(1);
		nmi_pin = 1;
		chk(mode_status, 8'h00);
		chk(cpu_clk_en, 8'h01);
		chk(periph_suspend, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_idle;
		for (int s = 0; s < 3; s++) begin
			req(2'h1);
			chk(cpu_clk_en, 8'h00);
			chk(mode_status, 8'h01);
			chk(mem_access_en, 8'h01);
			periph_irq = 8'h10;
			cyc(3);
			periph_irq = 8'h00;
			chk(mode_status, 8'h01);
			chk(periph_clk_en, 8'hbd);
			req(2'h2);
			chk(mode_status, 8'h01);
			wake(s);
		end
	endtask
	task t_sleep;
		for (int s = 0; s < 3; s++) begin
			req(2'h2);
			chk(periph_suspend, 8'hfa);
			chk(periph_clk_en & 8'hfa, 8'h38);
			cyc(8);
			chk(periph_clk_en, 8'h05);
			chk(mode_status, 8'h02);
			chk(mem_access_en, 8'h00);
			periph_irq = 8'h02;
			cyc(3);
			periph_irq = 8'h00;
			chk(mode_status, 8'h02);
			wake(s);
		end
	endtask
	task t_reset;
		req(2'h2);
		cyc(6);
		chk(mode_status, 8'h02);
		rst_b = 0;
		cyc(2);
		chk(periph_suspend, 8'h00);
		chk({cpu_clk_en, mem_access_en, mode_status}, 8'h0c);
		rst_b = 1;
		cyc(2);
		chk(periph_clk_en, 8'h3c);
	endtask
	task t_refuse;
		req(2'h3);
		cyc(1);
		chk(mode_status, 8'h00);
		chk(cpu_clk_en, 8'h01);
	endtask
	task t_auto;
		periph_busy = 8'h00;
		cyc(pmc_pkg::AUTO_OFF_CYC + 8);
		chk(periph_clk_en, 8'h00);
		periph_busy = 8'h04;
		cyc(2);
		chk(periph_clk_en, 8'h04);
		periph_busy = 8'hff;
		cyc(2);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		wrap_up;
	end
	initial begin
		cyc(12);
		chk(periph_clk_en, 8'h00);
		chk({cpu_clk_en, mem_access_en, mode_status}, 8'h0c);
		rst_b = 1;
		cyc(2);
		chk(periph_clk_en, 8'h3c);
		t_idle;
		t_sleep;
		t_reset;
		t_refuse;
		t_auto;
		wrap_up;
	end
endmodule
